/* design/adc_config_test_register_bank.sv */
// shadowed configuration bank with per-channel test word outputs
// assumes the serial front end hands over one byte access per wr_i/rd_i pulse on clk_i
`timescale 1ns/1ps
`default_nettype none
module adc_config_test_register_bank
	import adc_cfg_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic [7:0]  addr_i,
	input  wire logic [7:0]  wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [7:0]  rdata_o,
	input  wire logic [13:0] sample_a_i,
	input  wire logic [13:0] sample_b_i,
	output logic      [13:0] data_a_o,
	output logic      [13:0] data_b_o,
	output logic             div_clk_en_o,
	output logic      [7:0]  modes_a_o,
	output logic      [7:0]  modes_b_o,
	output logic             duty_stabilize_o,
	output logic      [7:0]  self_test_o,
	output logic      [7:0]  offset_trim_a_o,
	output logic      [7:0]  offset_trim_b_o
);
	// shadow (master) and active (slave) copies, index 0 = channel A, 1 = channel B
	logic [7:0] sh_modes [2];
	logic [7:0] sh_test  [2];
	logic [7:0] sh_trim  [2];
	logic [7:0] sh_clock, sh_div, sh_self, sh_plo, sh_phi;
	logic [7:0] ac_modes [2];
	logic [7:0] ac_test  [2];
	logic [7:0] ac_trim  [2];
	logic [7:0] ac_clock, ac_div, ac_self, ac_plo, ac_phi;
	logic [7:0] chan_index;
	logic [7:0] next_chan_index;
	logic [7:0] next_sh_modes [2];
	logic [7:0] next_sh_test  [2];
	logic [7:0] next_sh_trim  [2];
	logic [7:0] next_sh_clock, next_sh_div, next_sh_self, next_sh_plo, next_sh_phi;
	logic       transfer;
	logic       next_transfer;
	logic [7:0] next_rdata;
	logic [2:0] div_cnt;
	logic [2:0] next_div_cnt;
	logic       next_div_en;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction

	// register writes land in the shadow copies only; channel index and shadow update take effect directly
	always_comb begin
		next_chan_index = chan_index;
		next_sh_clock = sh_clock;
		next_sh_div   = sh_div;
		next_sh_self  = sh_self;
		next_sh_plo   = sh_plo;
		next_sh_phi   = sh_phi;
		// transfer self-clears the cycle after it is set
		next_transfer = 1'b0;
		for (int c = 0; c < 2; c++) begin
			next_sh_modes[c] = sh_modes[c];
			next_sh_test[c]  = sh_test[c];
			next_sh_trim[c]  = sh_trim[c];
			if (wr_i && chan_index[c]) begin
				if (hit(addr_i, offs_operating_modes))
					next_sh_modes[c] = wdata_i;
				if (hit(addr_i, offs_test_select))
					next_sh_test[c] = wdata_i;
				if (hit(addr_i, offs_offset_trim))
					next_sh_trim[c] = wdata_i;
			end
		end
		if (wr_i) begin
			if (hit(addr_i, offs_channel_index))
				next_chan_index = {6'h00, wdata_i[1:0]};
			if (hit(addr_i, offs_clock_config))
				next_sh_clock = {7'h00, wdata_i[0]};
			if (hit(addr_i, offs_clock_divider))
				next_sh_div = {5'h00, wdata_i[2:0]};
			if (hit(addr_i, offs_self_test))
				next_sh_self = {5'h00, wdata_i[2], 1'b0, wdata_i[0]};
			if (hit(addr_i, offs_user_patt_lo))
				next_sh_plo = wdata_i;
			if (hit(addr_i, offs_user_patt_hi))
				next_sh_phi = wdata_i;
			if (hit(addr_i, offs_shadow_update))
				next_transfer = wdata_i[pos_transfer];
		end
	end

	// reads return shadow values; with both channels selected channel A answers
	always_comb begin
		logic sel;
		sel = !chan_index[0];
		next_rdata = rdata_o;
		if (rd_i) begin
			case (addr_i)
				offs_channel_index:   next_rdata = chan_index;
				offs_operating_modes: next_rdata = sh_modes[sel];
				offs_clock_config:    next_rdata = sh_clock;
				offs_clock_divider:   next_rdata = sh_div;
				offs_test_select:     next_rdata = sh_test[sel];
				offs_self_test:       next_rdata = sh_self;
				offs_offset_trim:     next_rdata = sh_trim[sel];
				offs_user_patt_lo:    next_rdata = sh_plo;
				offs_user_patt_hi:    next_rdata = sh_phi;
				offs_shadow_update:   next_rdata = {7'h00, transfer};
				default:              next_rdata = 8'h00;
			endcase
		end
	end

	// divider: one enable pulse every ratio+1 clocks from the active ratio
	always_comb begin
		next_div_en  = (div_cnt == ac_div[2:0]);
		next_div_cnt = next_div_en ? 3'h0 : div_cnt + 3'h1;
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			chan_index <= rst_channel_index;
			sh_clock <= rst_zero;
			sh_div   <= rst_zero;
			sh_self  <= rst_zero;
			sh_plo   <= rst_zero;
			sh_phi   <= rst_zero;
			ac_clock <= rst_zero;
			ac_div   <= rst_zero;
			ac_self  <= rst_zero;
			ac_plo   <= rst_zero;
			ac_phi   <= rst_zero;
			transfer <= 1'b0;
			rdata_o  <= 8'h00;
			div_cnt  <= 3'h0;
			div_clk_en_o <= 1'b0;
			for (int c = 0; c < 2; c++) begin
				sh_modes[c] <= rst_operating_modes;
				sh_test[c]  <= rst_zero;
				sh_trim[c]  <= rst_zero;
				ac_modes[c] <= rst_operating_modes;
				ac_test[c]  <= rst_zero;
				ac_trim[c]  <= rst_zero;
			end
		end else begin
			chan_index <= next_chan_index;
			sh_clock <= next_sh_clock;
			sh_div   <= next_sh_div;
			sh_self  <= next_sh_self;
			sh_plo   <= next_sh_plo;
			sh_phi   <= next_sh_phi;
			transfer <= next_transfer;
			rdata_o  <= next_rdata;
			div_cnt  <= next_div_cnt;
			div_clk_en_o <= next_div_en;
			for (int c = 0; c < 2; c++) begin
				sh_modes[c] <= next_sh_modes[c];
				sh_test[c]  <= next_sh_test[c];
				sh_trim[c]  <= next_sh_trim[c];
			end
			// all shadowed registers move together so settings never mix
			if (transfer) begin
				ac_clock <= sh_clock;
				ac_div   <= sh_div;
				ac_self  <= sh_self;
				ac_plo   <= sh_plo;
				ac_phi   <= sh_phi;
				for (int c = 0; c < 2; c++) begin
					ac_modes[c] <= sh_modes[c];
					ac_test[c]  <= sh_test[c];
					ac_trim[c]  <= sh_trim[c];
				end
			end
		end
	end

	assign modes_a_o        = ac_modes[0];
	assign modes_b_o        = ac_modes[1];
	assign duty_stabilize_o = ac_clock[0];
	assign self_test_o      = ac_self;
	assign offset_trim_a_o  = ac_trim[0];
	assign offset_trim_b_o  = ac_trim[1];

	test_word_gen u_gen_a (
		.clk_i       (clk_i),
		.sys_rst_i   (sys_rst_i),
		.code_i      (ac_test[0][3:0]),
		.user_patt_i ({ac_phi, ac_plo}),
		.sample_i    (sample_a_i),
		.data_o      (data_a_o)
	);
	test_word_gen u_gen_b (
		.clk_i       (clk_i),
		.sys_rst_i   (sys_rst_i),
		.code_i      (ac_test[1][3:0]),
		.user_patt_i ({ac_phi, ac_plo}),
		.sample_i    (sample_b_i),
		.data_o      (data_b_o)
	);

	chk_transfer_clears: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		transfer |=> !transfer || $past(wr_i && addr_i == 8'hff && wdata_i[0]))
		else $error("transfer bit did not clear");
	chk_hold_until_xfer: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!transfer |=> ac_test[0] == $past(ac_test[0]) && ac_div == $past(ac_div))
		else $error("active register changed without transfer");
	chk_xfer_applies: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		transfer |=> ac_trim[1] == $past(sh_trim[1]) && ac_plo == $past(sh_plo))
		else $error("transfer did not copy shadow");
	chk_chan_steer: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		wr_i && addr_i == 8'h10 && chan_index[1:0] == 2'b01 |=> sh_trim[1] == $past(sh_trim[1]))
		else $error("write reached unselected channel");
	chk_read_chan_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		rd_i && addr_i == 8'h10 && chan_index[1:0] == 2'b11 |=> rdata_o == $past(sh_trim[0]))
		else $error("dual select read not channel A");
	chk_div_period: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		div_clk_en_o && ac_div == 8'h02 && !transfer ##1 !transfer ##1 !transfer
		|-> !div_clk_en_o && $past(!div_clk_en_o) ##1 div_clk_en_o)
		else $error("divide by three period wrong");
	cov_transfer:  cover property (@(posedge clk_i) wr_i && addr_i == 8'hff ##1 transfer);
	cov_both_chan: cover property (@(posedge clk_i) wr_i && chan_index[1:0] == 2'b11);
	cov_div_eight: cover property (@(posedge clk_i) div_clk_en_o && ac_div == 8'h07);
endmodule
`default_nettype wire

/* design/test_word_gen.sv */
// per-channel output test word generator
// assumes the code and user pattern come from the active (transferred) registers
`timescale 1ns/1ps
`default_nettype none
module test_word_gen
	import adc_cfg_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic [3:0]  code_i,
	input  wire logic [15:0] user_patt_i,
	input  wire logic [13:0] sample_i,
	output logic      [13:0] data_o
);
	logic [22:0] long_lfsr;
	logic [22:0] next_long_lfsr;
	logic [8:0]  short_lfsr;
	logic [8:0]  next_short_lfsr;
	logic        phase;
	logic        next_phase;
	logic [13:0] mix_cnt;
	logic [13:0] next_mix_cnt;
	logic [13:0] word;
	logic [13:0] next_data;

	always_comb begin
		next_long_lfsr  = {long_lfsr[21:0], long_lfsr[22] ^ long_lfsr[17]};
		next_short_lfsr = {short_lfsr[7:0], short_lfsr[8] ^ short_lfsr[4]};
		next_phase      = ~phase;
		next_mix_cnt    = mix_cnt + 14'h0001;
		case (test_code_t'(code_i))
			tp_midscale:    word = word_midscale;
			tp_pos_full:    word = word_pos_full;
			tp_neg_full:    word = word_neg_full;
			tp_checker:     word = phase ? ~word_checker : word_checker;
			tp_long_prs:    word = long_lfsr[13:0];
			tp_short_prs:   word = {short_lfsr[4:0], short_lfsr};
			tp_word_toggle: word = {14{phase}};
			tp_user:        word = user_patt_i[15:2];
			tp_bit_toggle:  word = phase ? 14'h1555 : 14'h2aaa;
			// each bit toggles at half the rate of the bit below
			tp_mixed_freq:  word = mix_cnt;
			default:        word = sample_i;
		endcase
		// unknown codes fall back to live samples so the pins never freeze
		next_data = (code_i != 4'h0) ? word : sample_i;
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			long_lfsr  <= 23'h7fffff;
			short_lfsr <= 9'h1ff;
			phase      <= 1'b0;
			mix_cnt    <= 14'h0000;
			data_o     <= 14'h0000;
		end else begin
			long_lfsr  <= next_long_lfsr;
			short_lfsr <= next_short_lfsr;
			phase      <= next_phase;
			mix_cnt    <= next_mix_cnt;
			data_o     <= next_data;
		end
	end

	chk_pos_full_word: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		code_i == 4'h2 |=> data_o == 14'h3fff)
		else $error("positive full scale word wrong");
	chk_word_toggle_alt: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		code_i == 4'h7 && $past(code_i) == 4'h7 |=> data_o == ~$past(data_o))
		else $error("word toggle did not alternate");
	chk_normal_pass: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		code_i == 4'h0 |=> data_o == $past(sample_i))
		else $error("normal data not passed through");
	chk_mixed_count: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		code_i == 4'hc && $past(code_i) == 4'hc |=> data_o == $past(data_o) + 14'h0001)
		else $error("mixed frequency pattern did not advance");
	cov_long_prs: cover property (@(posedge clk_i) code_i == 4'h5 ##1 code_i == 4'h5);
endmodule
`default_nettype wire

/* shared/adc_cfg_pkg.sv */
// register map, field positions, reset values and test codes of the configuration bank
// assumes a 40 MHz converter clock and a byte-wide register port driven by the serial front end
`default_nettype none
package adc_cfg_pkg;
	localparam logic [7:0] offs_channel_index  = 8'h05;
	localparam logic [7:0] offs_operating_modes = 8'h08;
	localparam logic [7:0] offs_clock_config   = 8'h09;
	localparam logic [7:0] offs_clock_divider  = 8'h0b;
	localparam logic [7:0] offs_test_select    = 8'h0d;
	localparam logic [7:0] offs_self_test      = 8'h0e;
	localparam logic [7:0] offs_offset_trim    = 8'h10;
	localparam logic [7:0] offs_user_patt_lo   = 8'h19;
	localparam logic [7:0] offs_user_patt_hi   = 8'h1a;
	localparam logic [7:0] offs_shadow_update  = 8'hff;

	localparam logic [7:0] rst_channel_index   = 8'h03;
	localparam logic [7:0] rst_operating_modes = 8'h80;
	localparam logic [7:0] rst_zero            = 8'h00;

	localparam int pos_div_lsb   = 0;
	localparam int pos_test_lsb  = 0;
	localparam int pos_transfer  = 0;

	typedef enum logic [3:0] {
		tp_off         = 4'h0,
		tp_midscale    = 4'h1,
		tp_pos_full    = 4'h2,
		tp_neg_full    = 4'h3,
		tp_checker     = 4'h4,
		tp_long_prs    = 4'h5,
		tp_short_prs   = 4'h6,
		tp_word_toggle = 4'h7,
		tp_user        = 4'h8,
		tp_bit_toggle  = 4'h9,
		tp_mixed_freq  = 4'hc
	} test_code_t;

	localparam logic [13:0] word_midscale = 14'h2000;
	localparam logic [13:0] word_pos_full = 14'h3fff;
	localparam logic [13:0] word_neg_full = 14'h0000;
	localparam logic [13:0] word_checker  = 14'h2aaa;
endpackage
`default_nettype wire

/* sim/adc_config_test_register_bank_tb.sv */
// self-checking bench for the shadowed configuration bank
// assumes host_port_model drives the register port; the bench drives the samples
`timescale 1ns/1ps
`default_nettype none
module adc_config_test_register_bank_tb
	import adc_cfg_pkg::*;
;
	logic        clk_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic [7:0]  addr, wdata, rdata, modes_a, modes_b, self_test, trim_a, trim_b, rv;
	logic        wr, rd, div_en, duty;
	logic [13:0] sample_a_i = 14'h0;
	logic [13:0] sample_b_i = 14'h0;
	logic [13:0] data_a, data_b;
	logic [13:0] v[4];
	logic [15:0] user;
	int          mismatches = 0;
	int          cmp_count = 0;
	int          cycles = 0;
	int          n;
	logic [7:0]  ra[11] = '{8'h05, 8'h08, 8'h09, 8'h0b, 8'h0d, 8'h0e, 8'h10, 8'h19, 8'h1a, 8'hff, 8'h13};
	logic [7:0]  re[11] = '{8'h03, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

	adc_config_test_register_bank uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr),
		.wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .sample_a_i(sample_a_i),
		.sample_b_i(sample_b_i), .data_a_o(data_a), .data_b_o(data_b), .div_clk_en_o(div_en),
		.modes_a_o(modes_a), .modes_b_o(modes_b), .duty_stabilize_o(duty),
		.self_test_o(self_test), .offset_trim_a_o(trim_a), .offset_trim_b_o(trim_b));
	host_port_model host (.clk_i(clk_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd),
		.rdata_i(rdata));

	always #12.5 clk_i = ~clk_i;
	// run needs about 360 cycles; generous ceiling
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 8000) begin
			mismatches++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		if (mismatches == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// pseudorandom codes are only required to move every cycle; the mixed pattern counts up
	function automatic bit word_ok(input logic [3:0] c, input logic [13:0] a, input logic [13:0] b,
		input logic [13:0] s, input logic [13:0] u);
		case (c)
			4'h1: return a === word_midscale && b === word_midscale;
			4'h2: return a === word_pos_full && b === word_pos_full;
			4'h3: return a === word_neg_full && b === word_neg_full;
			4'h4, 4'h9: return (a === 14'h2aaa && b === 14'h1555) || (a === 14'h1555 && b === 14'h2aaa);
			4'h7: return (a === 14'h3fff && b === 14'h0000) || (a === 14'h0000 && b === 14'h3fff);
			4'h8: return a === u && b === u;
			4'h5, 4'h6: return a !== b;
			4'hc: return b === a + 14'h0001;
			default: return a === s && b === s;
		endcase
	endfunction
	task automatic wait_pulse(output int k);
		k = 0;
		do begin
			@(posedge clk_i);
			#1;
			k++;
		end while (div_en !== 1'b1 && k < 20);
	endtask

	initial begin
		void'($urandom(32'h08dc));
		repeat (5) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		#1;
		chk(16'({modes_a, modes_b}), 16'h8080);
		for (int i = 0; i < 11; i++) begin
			host.read_reg(ra[i], rv);
			chk(16'(rv), 16'(re[i]));
		end
		for (int r = 7; r >= 0; r--) begin
			host.write_reg(offs_clock_divider, 8'(r));
			host.transfer();
			repeat (4) @(posedge clk_i);
			wait_pulse(n);
			wait_pulse(n);
			chk(16'(n), 16'(r + 1));
		end
		user = 16'($urandom);
		host.write_reg(offs_user_patt_lo, user[7:0]);
		host.write_reg(offs_user_patt_hi, user[15:8]);
		host.read_reg(offs_user_patt_hi, rv);
		chk(16'(rv), 16'(user[15:8]));
		for (int c = 0; c < 16; c++) begin
			@(posedge clk_i);
			sample_a_i <= 14'($urandom);
			sample_b_i <= 14'($urandom);
			host.write_reg(offs_test_select, 8'(c));
			host.transfer();
			repeat (3) @(posedge clk_i);
			#1;
			v[0] = data_a;
			v[2] = data_b;
			@(posedge clk_i);
			#1;
			v[1] = data_a;
			v[3] = data_b;
			chk(16'(word_ok(4'(c), v[0], v[1], sample_a_i, user[15:2])), 16'h1);
			chk(16'(word_ok(4'(c), v[2], v[3], sample_b_i, user[15:2])), 16'h1);
		end
		host.write_reg(offs_test_select, 8'h00);
		host.transfer();
		host.select(2'b01);
		host.write_reg(offs_test_select, 8'h02);
		host.write_reg(offs_offset_trim, 8'h5a);
		host.select(2'b10);
		host.write_reg(offs_test_select, 8'h03);
		host.write_reg(offs_offset_trim, 8'ha5);
		host.write_reg(offs_self_test, 8'h05);
		host.write_reg(offs_clock_config, 8'h01);
		host.write_reg(offs_operating_modes, 8'h01);
		host.read_reg(offs_offset_trim, rv);
		chk(16'(rv), 16'h00a5);
		host.select(2'b11);
		host.read_reg(offs_offset_trim, rv);
		chk(16'(rv), 16'h005a);
		chk(16'(data_a), 16'(sample_a_i));
		chk({trim_a, trim_b}, 16'h0000);
		chk(16'({duty, self_test}), 16'h0000);
		chk({modes_a, modes_b}, 16'h8080);
		host.transfer();
		repeat (3) @(posedge clk_i);
		#1;
		chk(16'(data_a), 16'(word_pos_full));
		chk(16'(data_b), 16'(word_neg_full));
		chk({trim_a, trim_b}, 16'h5aa5);
		chk(16'({duty, self_test}), 16'h0105);
		chk({modes_a, modes_b}, 16'h8001);
		give_verdict();
	end
endmodule
`default_nettype wire

/* sim/host_port_model.sv */
// host-side model of the byte register port: single-byte writes and reads
// assumes the bank takes a request on the rising edge where its strobe is high
`timescale 1ns/1ps
`default_nettype none
module host_port_model
	import adc_cfg_pkg::*;
(
	input  wire logic       clk_i,
	output logic      [7:0] addr_o,
	output logic      [7:0] wdata_o,
	output logic            wr_o,
	output logic            rd_o,
	input  wire logic [7:0] rdata_i
);
	initial begin
		addr_o = 8'h00;
		wdata_o = 8'h00;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end
	// released lines show the inverse so a stale value never passes for a fresh one
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge clk_i);
		wr_o <= 1'b0;
		addr_o <= ~a;
		wdata_o <= ~d;
	endtask
	task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clk_i);
		rd_o <= 1'b0;
		addr_o <= ~a;
		@(posedge clk_i);
		#1;
		d = rdata_i;
	endtask
	task automatic transfer();
		write_reg(offs_shadow_update, 8'h01);
	endtask
	task automatic select(input logic [1:0] ch);
		write_reg(offs_channel_index, {6'h00, ch});
	endtask
endmodule
`default_nettype wire
